// >>> pssr_pkg.sv
`default_nettype none
package pssr_pkg;
    // Frame geometry on the command line
    localparam int START_BITS = 3;
    localparam int SETUP_BITS = 4;
    localparam int STOP_BITS = 3;
    localparam int ACK_CLOCKS = 2;
    localparam int WORD_W = 16;
    localparam int READ_CLOCKS = 17;
    localparam int RESET_W = 21;
    // Reset pattern and command codes
    localparam logic [RESET_W-1:0] RESET_PATTERN = 21'h155540;
    localparam logic [SETUP_BITS-1:0] CMD_PRESSURE = 4'hA;
    localparam logic [SETUP_BITS-1:0] CMD_TEMPERATURE = 4'h9;
    localparam logic [SETUP_BITS-1:0] CMD_CAL_FIRST = 4'h5;
    localparam logic [SETUP_BITS-1:0] CMD_CAL_SECOND = 4'h6;
    localparam logic [SETUP_BITS-1:0] CMD_CAL_THIRD = 4'h3;
    localparam logic [SETUP_BITS-1:0] CMD_CAL_FOURTH = 4'hC;
    localparam logic [1:0] CAL_IDX_FIRST = 2'h0;
    localparam logic [1:0] CAL_IDX_SECOND = 2'h1;
    localparam logic [1:0] CAL_IDX_THIRD = 2'h2;
    localparam logic [1:0] CAL_IDX_FOURTH = 2'h3;
    // Link bit counter and its end values
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] START_LAST = CNT_W'(START_BITS - 1);
    localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SETUP_BITS - 1);
    localparam logic [CNT_W-1:0] STOP_LAST = CNT_W'(STOP_BITS - 1);
    localparam logic [CNT_W-1:0] ACK_LAST = CNT_W'(ACK_CLOCKS - 1);
    localparam logic [CNT_W-1:0] READ_LAST = CNT_W'(READ_CLOCKS - 1);
    // Conversion time, longest figure, counted in conversion clock periods
    localparam int CONV_TIME_MS = 35;
    localparam int MCLK_HZ = 32768;
    localparam int CONV_MCLK_CYCLES = (CONV_TIME_MS * MCLK_HZ) / 1000;
    typedef enum logic [2:0] {LK_HUNT, LK_SETUP, LK_STOP, LK_ACK, LK_READ} pssr_link_t;
    typedef enum logic [1:0] {CORE_IDLE, CORE_CONV, CORE_READY} pssr_core_t;
    // Command classification, used by the frame decoder and its selector
    function automatic logic pssr_is_conv(input logic [SETUP_BITS-1:0] c);
        return (c == CMD_PRESSURE) || (c == CMD_TEMPERATURE);
    endfunction
    function automatic logic pssr_is_cal(input logic [SETUP_BITS-1:0] c);
        return (c == CMD_CAL_FIRST) || (c == CMD_CAL_SECOND) ||
               (c == CMD_CAL_THIRD) || (c == CMD_CAL_FOURTH);
    endfunction
    function automatic logic [1:0] pssr_cal_index(input logic [SETUP_BITS-1:0] c);
        logic [1:0] idx;
        idx = CAL_IDX_FIRST;
        if (c == CMD_CAL_SECOND) idx = CAL_IDX_SECOND;
        if (c == CMD_CAL_THIRD) idx = CAL_IDX_THIRD;
        if (c == CMD_CAL_FOURTH) idx = CAL_IDX_FOURTH;
        return idx;
    endfunction
endpackage
`default_nettype wire

// >>> pssr_conv_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pssr_conv_if;
    logic start;
    logic abort;
    logic mclk_tick;
    logic done;
    modport ctrl (output start, output abort, output mclk_tick, input done);
    modport timer (input start, input abort, input mclk_tick, output done);
endinterface
`default_nettype wire

// >>> pssr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pssr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in, // Destination clock
    input wire logic rst_b_in, // Async reset, active low
    input wire logic [WIDTH-1:0] d_in, // Foreign levels
    output logic [WIDTH-1:0] q_out // Synchronised levels
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    if (WIDTH < 1) begin : g_bad_width
        $error("pssr_sync needs WIDTH of at least one");
    end
    // First stage feeds only the second stage
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end
    assign q_out = sync_q;
endmodule
`default_nettype wire

// >>> pssr_conv_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pssr_conv_timer
    import pssr_pkg::*;
#(
    parameter int CYCLES = CONV_MCLK_CYCLES
) (
    input wire logic clk_in, // System clock
    input wire logic rst_b_in, // Synchronised reset, active low
    pssr_conv_if.timer conv // Start, abort, tick and done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic run_q;
    logic run_d;
    logic done_q;
    logic done_d;
    if (CYCLES < 1) begin : g_bad_cycles
        $error("pssr_conv_timer needs CYCLES of at least one");
    end
    // Counts conversion clock ticks; abort beats start so a reset always wins
    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        done_d = 1'b0;
        if (conv.abort) begin
            run_d = 1'b0;
            cnt_d = '0;
        end else if (conv.start) begin
            run_d = 1'b1;
            cnt_d = '0;
        end else if (run_q && conv.mclk_tick) begin
            if (cnt_q == LAST) begin
                run_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            done_q <= done_d;
        end
    end
    assign conv.done = done_q;
endmodule
`default_nettype wire

// >>> pssr_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1 - Command bits are sampled and result bits launched on rising shift clock.
// R2 - Host captures results and changes commands on the falling shift clock.
// R3 - Only the host generates shift clock pulses.
// R4 - Result line carries conversion result or calibration word, chosen by last command.
// R5 - Result line also shows conversion status while a measurement runs.
// R6 - Every transaction starts with a command frame on the command line.
// R7 - Frames are three high bits, selection field, three low bits; no select.
// R8 - Selection field is four bits: pressure, temperature or calibration read.
// R9 - Seven operations: two conversions, four calibration reads, and reset.
// R10 - Conversion start is acknowledged by a low to high step on result line.
// R11 - Host gives exactly two clocks after the acknowledge, then pauses.
// R12 - Shift clock stays low until result line falls, marking conversion end.
// R13 - Host may use that falling edge as an interrupt.
// R14 - Seventeen further clocks shift the 16-bit result out.
// R15 - Readout may pause with clock held; shifting resumes from the same bit.
// R16 - Host reads the pending result before commanding a new conversion.
// R17 - The 21-bit reset pattern is recognised in any state and returns idle.
// R18 - Host ignores the result line during the reset pattern.
// R19 - Host should send the reset pattern before each conversion command.
// R20 - Calibration is four 16-bit words, one per read command.
// R21 - Host supplies a free conversion clock separate from the shift clock.
// R22 - Command and reset patterns are fixed codes; words go out MSB first.
// R23 - Latest result is held stable until read out or reset is seen.
module pssr_top
    import pssr_pkg::*;
#(
    parameter logic [WORD_W-1:0] CAL_WORD_FIRST = 16'h1111,
    parameter logic [WORD_W-1:0] CAL_WORD_SECOND = 16'h2222,
    parameter logic [WORD_W-1:0] CAL_WORD_THIRD = 16'h3333,
    parameter logic [WORD_W-1:0] CAL_WORD_FOURTH = 16'h4444,
    parameter int CONV_CYCLES = CONV_MCLK_CYCLES
) (
    input wire logic sys_clk_in, // System clock
    input wire logic rst_b_in, // Async reset, active low
    input wire logic sclk_in, // Shift clock from the host
    input wire logic din_in, // Command line
    input wire logic mclk_in, // Free conversion clock pin
    input wire logic [WORD_W-1:0] pressure_sample_in, // Converter pressure word
    input wire logic [WORD_W-1:0] temperature_sample_in, // Converter temperature word
    output logic dout_out, // Result line
    output logic adc_start_out, // One-cycle converter start
    output logic adc_chan_out, // Zero pressure, one temperature
    output logic conv_busy_out // Conversion in progress
);
    if (CONV_CYCLES < 1) begin : g_bad_conv
        $error("pssr_top needs CONV_CYCLES of at least one");
    end

    // Reset release, two flops on the system clock
    logic rst_b;
    pssr_sync #(
        .WIDTH(1)
    ) u_rst_sync (
        .clk_in(sys_clk_in),
        .rst_b_in(rst_b_in),
        .d_in(1'b1),
        .q_out(rst_b)
    );

    // Link domain registers, clocked by the shift clock
    pssr_link_t lk_q;
    pssr_link_t lk_d;
    logic [CNT_W-1:0] lcnt_q;
    logic [CNT_W-1:0] lcnt_d;
    logic [SETUP_BITS-1:0] setup_q;
    logic [SETUP_BITS-1:0] setup_d;
    logic [WORD_W-1:0] sh_q;
    logic [WORD_W-1:0] sh_d;
    logic bit_q;
    logic bit_d;
    logic is_conv_q;
    logic is_conv_d;
    logic [1:0] cal_sel_q;
    logic [1:0] cal_sel_d;
    logic ptgl_q;
    logic ptgl_d;
    logic ttgl_q;
    logic ttgl_d;
    logic rdtgl_q;
    logic rdtgl_d;
    logic rstgl_q;
    logic rstgl_d;
    logic [RESET_W-1:0] rhist_q;

    // Held result, written in the system domain
    logic [WORD_W-1:0] hold_q;
    logic [WORD_W-1:0] hold_d;

    // Reset pattern watch includes the bit of this edge
    wire [RESET_W-1:0] rhist_next = {rhist_q[RESET_W-2:0], din_in};
    wire reset_seen = (rhist_next == RESET_PATTERN); // R17
    wire [SETUP_BITS-1:0] setup_next = {setup_q[SETUP_BITS-2:0], din_in};
    wire [CNT_W-1:0] lcnt_inc = lcnt_q + 1'b1;

    // Word to shift: conversion result or one calibration word
    wire [WORD_W-1:0] cal_word = (cal_sel_q == CAL_IDX_FIRST) ? CAL_WORD_FIRST :
                                 (cal_sel_q == CAL_IDX_SECOND) ? CAL_WORD_SECOND :
                                 (cal_sel_q == CAL_IDX_THIRD) ? CAL_WORD_THIRD :
                                 CAL_WORD_FOURTH; // R20
    wire [WORD_W-1:0] src_word = is_conv_q ? hold_q : cal_word; // R4

    // Frame decoder; nothing but a command frame starts a transfer
    always_comb begin
        lk_d = lk_q;
        lcnt_d = lcnt_q;
        setup_d = setup_q;
        sh_d = sh_q;
        bit_d = bit_q;
        is_conv_d = is_conv_q;
        cal_sel_d = cal_sel_q;
        ptgl_d = ptgl_q;
        ttgl_d = ttgl_q;
        rdtgl_d = rdtgl_q;
        rstgl_d = rstgl_q;
        unique case (lk_q)
            LK_HUNT: begin
                // Three high bits in a row open a frame
                if (!din_in) begin
                    lcnt_d = '0;
                end else if (lcnt_q == START_LAST) begin
                    lk_d = LK_SETUP; // R6 R7
                    lcnt_d = '0;
                end else begin
                    lcnt_d = lcnt_inc;
                end
            end
            LK_SETUP: begin
                setup_d = setup_next; // R8
                if (lcnt_q == SETUP_LAST) begin
                    lk_d = LK_STOP;
                    lcnt_d = '0;
                end else begin
                    lcnt_d = lcnt_inc;
                end
            end
            LK_STOP: begin
                // A high bit here means broken framing: drop it
                if (din_in) begin
                    lk_d = LK_HUNT; // R7
                    lcnt_d = '0;
                end else if (lcnt_q == STOP_LAST) begin
                    lcnt_d = '0;
                    if (pssr_is_conv(setup_q)) begin
                        lk_d = LK_ACK; // R9
                        is_conv_d = 1'b1;
                        if (setup_q == CMD_PRESSURE) begin
                            ptgl_d = ~ptgl_q;
                        end else begin
                            ttgl_d = ~ttgl_q;
                        end
                    end else if (pssr_is_cal(setup_q)) begin
                        lk_d = LK_READ; // R9
                        is_conv_d = 1'b0;
                        cal_sel_d = pssr_cal_index(setup_q);
                    end else begin
                        lk_d = LK_HUNT;
                    end
                end else begin
                    lcnt_d = lcnt_inc;
                end
            end
            LK_ACK: begin
                // The two clocks after the acknowledge carry no data
                if (lcnt_q == ACK_LAST) begin
                    lk_d = LK_READ; // R11
                    lcnt_d = '0;
                end else begin
                    lcnt_d = lcnt_inc;
                end
            end
            LK_READ: begin
                // Held clock simply freezes the shifter, so readout resumes
                if (lcnt_q == '0) begin
                    bit_d = src_word[WORD_W-1]; // R14 R22
                    sh_d = {src_word[WORD_W-2:0], 1'b0};
                    lcnt_d = lcnt_inc;
                end else if (lcnt_q == READ_LAST) begin
                    bit_d = 1'b0;
                    rdtgl_d = ~rdtgl_q;
                    lk_d = LK_HUNT;
                    lcnt_d = '0;
                end else begin
                    bit_d = sh_q[WORD_W-1]; // R15
                    sh_d = {sh_q[WORD_W-2:0], 1'b0};
                    lcnt_d = lcnt_inc;
                end
            end
            default: begin
                lk_d = LK_HUNT;
            end
        endcase
        // Reset pattern overrides whatever the decoder was doing
        if (reset_seen) begin
            lk_d = LK_HUNT; // R17
            lcnt_d = '0;
            bit_d = 1'b0;
            rstgl_d = ~rstgl_q;
        end
    end

    // Link flops; the host keeps the clock still through reset
    always_ff @(posedge sclk_in or negedge rst_b) begin
        if (!rst_b) begin
            lk_q <= LK_HUNT;
            lcnt_q <= '0;
            setup_q <= '0;
            sh_q <= '0;
            bit_q <= 1'b0;
            is_conv_q <= 1'b0;
            cal_sel_q <= CAL_IDX_FIRST;
            ptgl_q <= 1'b0;
            ttgl_q <= 1'b0;
            rdtgl_q <= 1'b0;
            rstgl_q <= 1'b0;
            rhist_q <= '0;
        end else begin
            lk_q <= lk_d; // R1
            lcnt_q <= lcnt_d;
            setup_q <= setup_d;
            sh_q <= sh_d;
            bit_q <= bit_d; // R1
            is_conv_q <= is_conv_d;
            cal_sel_q <= cal_sel_d;
            ptgl_q <= ptgl_d;
            ttgl_q <= ttgl_d;
            rdtgl_q <= rdtgl_d;
            rstgl_q <= rstgl_d;
            rhist_q <= rhist_next;
        end
    end

    // Link events, data bit and conversion clock into the system domain
    logic [5:0] sync_out;
    logic mclk_s;
    logic ptgl_s;
    logic ttgl_s;
    logic rdtgl_s;
    logic rstgl_s;
    logic bit_s;
    pssr_sync #(
        .WIDTH(6)
    ) u_in_sync (
        .clk_in(sys_clk_in),
        .rst_b_in(rst_b),
        .d_in({mclk_in, ptgl_q, ttgl_q, rdtgl_q, rstgl_q, bit_q}),
        .q_out(sync_out)
    );
    assign {mclk_s, ptgl_s, ttgl_s, rdtgl_s, rstgl_s, bit_s} = sync_out;

    // Edge detection on the synchronised copies
    logic [4:0] prev_q;
    wire mclk_rise = mclk_s & ~prev_q[4]; // R21
    wire press_ev = ptgl_s ^ prev_q[3];
    wire temp_ev = ttgl_s ^ prev_q[2];
    wire read_ev = rdtgl_s ^ prev_q[1];
    wire rst_ev = rstgl_s ^ prev_q[0];

    // Conversion control
    pssr_core_t core_q;
    pssr_core_t core_d;
    logic dout_q;
    logic dout_d;
    logic start_q;
    logic start_d;
    logic chan_q;
    logic chan_d;
    logic busy_q;
    logic busy_d;
    logic abort_q;
    logic abort_d;
    pssr_conv_if conv_bus ();

    pssr_conv_timer #(
        .CYCLES(CONV_CYCLES)
    ) u_timer (
        .clk_in(sys_clk_in),
        .rst_b_in(rst_b),
        .conv(conv_bus)
    );
    assign conv_bus.start = start_q;
    assign conv_bus.abort = abort_q;
    assign conv_bus.mclk_tick = mclk_rise;

    // Result line owner: status while converting, link bit otherwise
    always_comb begin
        core_d = core_q;
        dout_d = bit_s; // R4
        start_d = 1'b0;
        chan_d = chan_q;
        busy_d = busy_q;
        abort_d = 1'b0;
        hold_d = hold_q;
        unique case (core_q)
            CORE_IDLE: begin
                if (press_ev || temp_ev) begin
                    core_d = CORE_CONV;
                    dout_d = 1'b1; // R10
                    start_d = 1'b1;
                    chan_d = temp_ev;
                    busy_d = 1'b1;
                end
            end
            CORE_CONV: begin
                dout_d = 1'b1; // R5
                if (conv_bus.done) begin
                    core_d = CORE_READY;
                    dout_d = 1'b0; // R12
                    busy_d = 1'b0;
                    hold_d = chan_q ? temperature_sample_in : pressure_sample_in; // R23
                end
            end
            CORE_READY: begin
                // New conversion requests are dropped until any readout ends, of this result or of a calibration word
                if (read_ev) begin
                    core_d = CORE_IDLE; // R23
                end
            end
            default: begin
                core_d = CORE_IDLE;
            end
        endcase
        // Reset pattern returns the core to idle and stops the timer
        if (rst_ev) begin
            core_d = CORE_IDLE; // R17
            dout_d = bit_s;
            busy_d = 1'b0;
            abort_d = 1'b1;
        end
    end

    // System flops; outputs come straight from these
    always_ff @(posedge sys_clk_in or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= '0;
            core_q <= CORE_IDLE;
            dout_q <= 1'b0;
            start_q <= 1'b0;
            chan_q <= 1'b0;
            busy_q <= 1'b0;
            abort_q <= 1'b0;
            hold_q <= '0;
        end else begin
            prev_q <= {mclk_s, ptgl_s, ttgl_s, rdtgl_s, rstgl_s};
            core_q <= core_d;
            dout_q <= dout_d;
            start_q <= start_d;
            chan_q <= chan_d;
            busy_q <= busy_d;
            abort_q <= abort_d;
            hold_q <= hold_d;
        end
    end

    assign dout_out = dout_q;
    assign adc_start_out = start_q;
    assign adc_chan_out = chan_q;
    assign conv_busy_out = busy_q;
endmodule
`default_nettype wire

// >>> pssr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pssr_monitor #(
    parameter int CONV_CYCLES = 4
) (
    input wire logic sys_clk_in, // System clock
    input wire logic rst_b_in, // Async reset, active low
    input wire logic dout_out, // Result line
    input wire logic adc_start_out, // Converter start pulse
    input wire logic adc_chan_out, // Channel, one is temperature
    input wire logic conv_busy_out // Conversion in progress
);
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    // Start is one cycle long and the acknowledge follows at once
    property p_start_pulse;
        adc_start_out |=> !adc_start_out;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
    property p_start_ack;
        adc_start_out |-> ##[0:2] dout_out;
    endproperty
    a_start_ack: assert property (p_start_ack) else $error("no acknowledge after start");
    // Status owns the result line from the start of a measurement
    property p_busy_status;
        $rose(conv_busy_out) |-> ##[0:2] dout_out;
    endproperty
    a_busy_status: assert property (p_busy_status) else $error("busy without status");
    // A second start while converting would lose the first result
    property p_single_start;
        adc_start_out |-> !$past(conv_busy_out);
    endproperty
    a_single_start: assert property (p_single_start) else $error("start while busy");
    property p_chan_stable;
        conv_busy_out && $past(conv_busy_out) |-> $stable(adc_chan_out);
    endproperty
    a_chan_stable: assert property (p_chan_stable) else $error("channel moved in flight");
    // Conversion spans at least eight system clocks, yet always ends
    property p_busy_min;
        $rose(conv_busy_out) |-> conv_busy_out [*8];
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("conversion too short");
    property p_busy_max;
        $rose(conv_busy_out) |-> ##[1:1000] !conv_busy_out;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("conversion never ends");
    property p_end_fall;
        $fell(conv_busy_out) |-> ##[0:2] !dout_out;
    endproperty
    a_end_fall: assert property (p_end_fall) else $error("no falling edge at end");
    property p_reset_quiet;
        $rose(rst_b_in) |-> (!dout_out && !conv_busy_out && !adc_start_out) [*2];
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
endmodule
bind pssr_top pssr_monitor #(.CONV_CYCLES(CONV_CYCLES)) i_mon (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .dout_out(dout_out),
    .adc_start_out(adc_start_out),
    .adc_chan_out(adc_chan_out),
    .conv_busy_out(conv_busy_out)
);
`default_nettype wire

// >>> pssr_host.sv
`timescale 1ns/1ps
`default_nettype none
module pssr_host
    import pssr_pkg::*;
(
    output logic sclk_out, // Shift clock, idles low
    output logic din_out, // Command line
    input wire logic dout_in // Result line
);
    logic bit_q;
    // Only the host ever makes shift clock pulses
    initial begin
        sclk_out = 1'b0;
        din_out = 1'b0;
    end
    // Command bit changes at the fall, result bit taken at the fall
    task automatic pulse(input logic b, output logic r);
        din_out = b;
        #24 sclk_out = 1'b1;
        #24 sclk_out = 1'b0;
        r = dout_in;
    endtask
    // Result line is not looked at while sending patterns
    task automatic send(input logic [RESET_W-1:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            pulse(v[i], bit_q);
        end
    endtask
    task automatic frame(input logic [SETUP_BITS-1:0] c);
        send({11'h000, 3'h7, c, 3'h0}, 10);
    endtask
    // Seventeen clocks, word MSB first, optional long hold mid-word
    task automatic read(input int hold_at, output logic [WORD_W-1:0] w);
        for (int k = 1; k <= READ_CLOCKS; k++) begin
            pulse(1'b0, bit_q);
            if (k <= WORD_W) w[WORD_W-k] = bit_q;
            if (k == hold_at) #700;
        end
    endtask
    // Bounded wait for a level on the result line, clock held low
    task automatic wait_level(input logic lvl, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 3000 && !ok; i++) begin
            #4 ok = (dout_in === lvl);
        end
    endtask
    task automatic convert(input logic [SETUP_BITS-1:0] c, output logic acked, output logic ended);
        send(RESET_PATTERN, RESET_W);
        frame(c);
        wait_level(1'b1, acked);
        ended = 1'b0;
        if (acked) begin
            pulse(1'b0, bit_q);
            pulse(1'b0, bit_q);
            wait_level(1'b0, ended);
        end
    endtask
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pssr_pkg::*;
    localparam logic [WORD_W-1:0] CW [4] = '{16'h8E31, 16'h47D2, 16'hB06C, 16'h19F5};
    localparam logic [SETUP_BITS-1:0] CC [4] = '{CMD_CAL_FIRST, CMD_CAL_SECOND,
        CMD_CAL_THIRD, CMD_CAL_FOURTH};
    logic sys_clk, rst_b, mclk, sclk, din, dout, adc_start, adc_chan, busy;
    logic [WORD_W-1:0] p_smp, t_smp;
    logic [WORD_W-1:0] exp_q [$];
    int errors = 0;
    int check_count = 0;
    int starts = 0;
    pssr_top #(.CAL_WORD_FIRST(CW[0]), .CAL_WORD_SECOND(CW[1]), .CAL_WORD_THIRD(CW[2]),
        .CAL_WORD_FOURTH(CW[3]), .CONV_CYCLES(4)) i_dut (
        .sys_clk_in(sys_clk), .rst_b_in(rst_b), .sclk_in(sclk), .din_in(din),
        .mclk_in(mclk), .pressure_sample_in(p_smp), .temperature_sample_in(t_smp),
        .dout_out(dout), .adc_start_out(adc_start), .adc_chan_out(adc_chan),
        .conv_busy_out(busy));
    pssr_host i_host (.sclk_out(sclk), .din_out(din), .dout_in(dout));
    // System clock and a free conversion clock, unrelated in phase
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        mclk = 1'b0;
        forever #100.3 mclk = ~mclk;
    end
    // Converter starts, counted mid-cycle where the pulse has settled
    always @(negedge sys_clk) begin
        if (adc_start === 1'b1) starts++;
    end
    task automatic check_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // New converter words; the model keeps what the sensor must hold
    task automatic new_samples;
        @(posedge sys_clk);
        p_smp <= WORD_W'($urandom);
        t_smp <= WORD_W'($urandom);
        @(posedge sys_clk);
    endtask
    initial begin
        #200000;
        errors++;
        close_out();
    end
    initial begin
        logic [WORD_W-1:0] w;
        logic a, e, c;
        rst_b = 1'b0;
        p_smp = '0;
        t_smp = '0;
        void'($urandom(32'hE4D7));
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge sys_clk);
        #1.7;
        // Every calibration word, back to back, one read held mid-word
        for (int i = 0; i < 4; i++) begin
            i_host.frame(CC[i]);
            i_host.read(i == 2 ? 7 : 0, w);
            check_word(w, CW[i]);
        end
        // Conversions on both channels; inputs change before readout
        for (int i = 0; i < 4; i++) begin
            c = i[0];
            new_samples();
            exp_q.push_back(c ? t_smp : p_smp);
            i_host.convert(c ? CMD_TEMPERATURE : CMD_PRESSURE, a, e);
            check_flag(a, 1'b1);
            check_flag(adc_chan, c);
            check_flag(e, 1'b1);
            check_flag(busy, 1'b0);
            new_samples();
            i_host.read(i == 1 ? 9 : 0, w);
            check_word(w, exp_q.pop_front());
        end
        // A frame with a bad stop bit is dropped, the next one is served
        i_host.frame(4'hF);
        check_flag(dout, 1'b0);
        i_host.send({11'h000, 3'h7, CMD_CAL_THIRD, 3'h2}, 10);
        i_host.frame(CMD_CAL_FIRST);
        i_host.read(0, w);
        check_word(w, CW[0]);
        // With a result pending a new conversion is refused
        new_samples();
        i_host.convert(CMD_PRESSURE, a, e);
        exp_q.push_back(p_smp);
        i_host.frame(CMD_TEMPERATURE);
        repeat (40) @(negedge sys_clk);
        check_flag(busy, 1'b0);
        check_flag(adc_chan, 1'b0);
        check_flag(dout, 1'b0);
        // Reset pattern mid-frame and mid-conversion drops everything
        i_host.send(RESET_PATTERN, RESET_W);
        exp_q.delete();
        i_host.send(21'h00001C, 5);
        i_host.send(RESET_PATTERN, RESET_W);
        i_host.frame(CMD_PRESSURE);
        i_host.wait_level(1'b1, a);
        check_flag(busy, 1'b1);
        i_host.send(RESET_PATTERN, RESET_W);
        repeat (20) @(negedge sys_clk);
        check_flag(busy, 1'b0);
        check_flag(dout, 1'b0);
        new_samples();
        exp_q.push_back(t_smp);
        i_host.convert(CMD_TEMPERATURE, a, e);
        check_flag(a & e, 1'b1);
        i_host.read(0, w);
        check_word(w, exp_q.pop_front());
        i_host.frame(CMD_CAL_FOURTH);
        i_host.read(0, w);
        check_word(w, CW[3]);
        check_word(WORD_W'(starts), 16'h0007);
        close_out();
    end
endmodule
`default_nettype wire
